// ---- ot_limit_cfg.svh ----
`ifndef OT_LIMIT_CFG_SVH
`define OT_LIMIT_CFG_SVH
// Command codes of the three limit/response registers.
`define CMD_FAULT_LIM   8'h4F
`define CMD_FAULT_ACT   8'h50
`define CMD_WARN_LIM    8'h51
// Reset values (mantissa, degrees C at zero exponent).
`define FAULT_LIM_RST   8'h91
`define WARN_LIM_RST    8'h78
`define RESP_SEL_RST    1'b0
`define RETRY_SEL_RST   1'b1
// Legal ranges.
`define FAULT_LIM_MIN   8'h78
`define FAULT_LIM_MAX   8'hA5
`define WARN_LIM_MIN    8'h64
`define WARN_LIM_MAX    8'h8C
// Derivation of the default warning limit.
`define WARN_OFFSET     8'h19
`define WARN_FLOOR      8'h64
// Latch release hysteresis in degrees.
`define HYST_DEG        8'h14
// Field positions in the fault action byte.
`define ACT_RESP_BIT    7
`define ACT_RETRY_BIT   5
// Retry delay in soft start ramp periods.
`define RETRY_PERIODS   10'h007
// Timing: one millisecond at a 10 ns clock.
`define MS_NS           1000000
`define CLK_NS          10
`define MS_CYCLES       (`MS_NS / `CLK_NS)
`endif

// ---- ot_limit_pkg.sv ----
package ot_limit_pkg;
   typedef logic [7:0] temp_t;
   typedef enum logic [1:0] {
      SEQ_RUN,
      SEQ_HOLD,
      SEQ_COOL,
      SEQ_DELAY
   } seq_state_t;
endpackage

// ---- hyst_flag.sv ----
`timescale 1ns/1ps
`include "ot_limit_cfg.svh"
// ----------------------------------------------------------------
// Latched threshold flag with a fixed release hysteresis.
// ----------------------------------------------------------------
module hyst_flag (
   input  wire logic                 core_clk,
   input  wire logic                 rst_b,
   input  wire ot_limit_pkg::temp_t  temp,
   input  wire ot_limit_pkg::temp_t  limit,
   output logic                      flag_q
);
   import ot_limit_pkg::*;

   // Only a restored fault limit can go below 100; one below 20 makes the subtraction wrap.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         flag_q <= 1'b0;
      end else if (temp > limit) begin
         flag_q <= 1'b1;
      end else if (temp <= limit - `HYST_DEG) begin
         flag_q <= 1'b0;
      end
   end
endmodule

// ---- retry_timer.sv ----
`timescale 1ns/1ps
`include "ot_limit_cfg.svh"
// ----------------------------------------------------------------
// Waits seven soft start ramp periods, then pulses done.
// ----------------------------------------------------------------
module retry_timer #(
   parameter int MS_CYC = `MS_CYCLES
) (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        start,
   input  wire logic [6:0]  ramp_ms,
   output logic             done
);
   import ot_limit_pkg::*;

   logic [16:0] ms_cnt_q;
   logic [9:0]  ms_left_q;
   logic        busy_q;
   logic [6:0]  ramp_eff;

   // A programmed ramp of zero still takes the fastest ramp of 1 ms.
   assign ramp_eff = (ramp_ms == 7'h00) ? 7'h01 : ramp_ms;
   assign done = busy_q && (ms_left_q == 10'h001) && (ms_cnt_q == 17'(MS_CYC - 1));

   // Millisecond prescaler and period countdown.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_q    <= 1'b0;
         ms_cnt_q  <= 17'h00000;
         ms_left_q <= 10'h000;
      end else if (start) begin
         busy_q    <= 1'b1;
         ms_cnt_q  <= 17'h00000;
         ms_left_q <= 10'(`RETRY_PERIODS * ramp_eff);
      end else if (busy_q) begin
         if (ms_cnt_q == 17'(MS_CYC - 1)) begin
            ms_cnt_q  <= 17'h00000;
            ms_left_q <= ms_left_q - 10'h001;
            busy_q    <= (ms_left_q != 10'h001);
         end else begin
            ms_cnt_q <= ms_cnt_q + 17'h00001;
         end
      end
   end
endmodule

// ---- ot_limit_regs.sv ----
`timescale 1ns/1ps
`include "ot_limit_cfg.svh"
module ot_limit_regs #(
   parameter int MS_CYC = `MS_CYCLES
) (
   input  wire logic                 core_clk,
   input  wire logic                 rst_b,
   input  wire logic                 cmd_wr,
   input  wire logic                 cmd_rd,
   input  wire logic [7:0]           cmd_code,
   input  wire logic [15:0]          cmd_wdata,
   output logic [15:0]               rd_data_q,
   output logic                      rd_valid_q,
   input  wire logic                 clear_faults,
   input  wire logic                 limit_check_override,
   input  wire ot_limit_pkg::temp_t  temp_sense,
   input  wire logic                 bandgap_ot_pin,
   input  wire logic                 power_on_cmd,
   input  wire logic [6:0]           soft_start_ramp_time,
   input  wire logic                 save_all_to_nvm,
   input  wire logic                 nvm_restore,
   input  wire ot_limit_pkg::temp_t  nvm_fault_lim,
   input  wire logic                 nvm_resp_sel,
   input  wire logic                 nvm_retry_sel,
   output logic                      nvm_save_q,
   output ot_limit_pkg::temp_t       nvm_fault_lim_q,
   output logic                      nvm_resp_sel_q,
   output logic                      nvm_retry_sel_q,
   output logic                      comm_logic_fault,
   output logic                      invalid_data_flag,
   output logic                      status_byte_overtemp_flag,
   output logic                      status_byte_temp,
   output logic                      temp_fault_flag,
   output logic                      temp_warning_level,
   output logic                      smbalert,
   output logic                      output_enable,
   output logic                      soft_start_q
);
   import ot_limit_pkg::*;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic in_range(temp_t v, temp_t lo, temp_t hi);
      return (v >= lo) && (v <= hi);
   endfunction

   function automatic temp_t warn_default(temp_t f);
      return (f < `WARN_FLOOR + `WARN_OFFSET) ? `WARN_FLOOR : temp_t'(f - `WARN_OFFSET);
   endfunction

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   temp_t       fault_lim_q;
   temp_t       warn_lim_q;
   logic        resp_sel_q;
   logic        retry_sel_q;
   logic        cml_q;
   logic        ivd_q;
   logic        sb_ot_q;
   logic        sb_temp_q;
   logic        tf_q;
   logic        tw_q;
   logic        bg_meta_q;
   logic        bg_q;
   seq_state_t  state_q;
   logic        fault_flag;
   logic        warn_flag;
   logic        timer_done;
   logic        timer_start;
   logic        cooled;
   logic        shut_req;
   logic        wr_fault;
   logic        wr_warn;
   logic        wr_act;
   logic        fault_ok;
   logic        warn_ok;
   logic        act_ok;
   logic        reject;
   logic [2:0]  new_retry;
   temp_t       wr_mant;

   // Only the low byte carries the mantissa; the upper byte is fixed.
   assign wr_mant   = cmd_wdata[7:0];
   assign new_retry = cmd_wdata[5:3];
   assign wr_fault  = cmd_wr && (cmd_code == `CMD_FAULT_LIM);
   assign wr_warn   = cmd_wr && (cmd_code == `CMD_WARN_LIM);
   assign wr_act    = cmd_wr && (cmd_code == `CMD_FAULT_ACT);

   // Consistency is judged against the other limit as it stands now.
   assign fault_ok = in_range(wr_mant, `FAULT_LIM_MIN, `FAULT_LIM_MAX)
                     && (wr_mant > warn_lim_q);
   assign warn_ok  = in_range(wr_mant, `WARN_LIM_MIN, `WARN_LIM_MAX)
                     && (limit_check_override || (wr_mant < fault_lim_q));
   assign act_ok   = (new_retry == 3'b000) || (new_retry == 3'b111);
   assign reject   = (wr_fault && !fault_ok) || (wr_warn && !warn_ok) || (wr_act && !act_ok);

   // ----------------------------------------------------------------
   // Limit and response storage
   // ----------------------------------------------------------------
   // A restore reloads from storage and rebuilds the warning default.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         fault_lim_q <= `FAULT_LIM_RST;
         warn_lim_q  <= `WARN_LIM_RST;
         resp_sel_q  <= `RESP_SEL_RST;
         retry_sel_q <= `RETRY_SEL_RST;
      end else if (nvm_restore) begin
         fault_lim_q <= nvm_fault_lim;
         warn_lim_q  <= warn_default(nvm_fault_lim);
         resp_sel_q  <= nvm_resp_sel;
         retry_sel_q <= nvm_retry_sel;
      end else begin
         if (wr_fault && fault_ok) begin
            fault_lim_q <= wr_mant;
         end
         if (wr_warn && warn_ok) begin
            warn_lim_q <= wr_mant;
         end
         if (wr_act && act_ok) begin
            resp_sel_q  <= cmd_wdata[`ACT_RESP_BIT];
            retry_sel_q <= cmd_wdata[`ACT_RETRY_BIT];
         end
      end
   end

   // Save copies only the stored bits; delay bits are implied by bit 5.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         nvm_save_q      <= 1'b0;
         nvm_fault_lim_q <= `FAULT_LIM_RST;
         nvm_resp_sel_q  <= `RESP_SEL_RST;
         nvm_retry_sel_q <= `RETRY_SEL_RST;
      end else begin
         nvm_save_q <= save_all_to_nvm;
         if (save_all_to_nvm) begin
            nvm_fault_lim_q <= fault_lim_q;
            nvm_resp_sel_q  <= resp_sel_q;
            nvm_retry_sel_q <= retry_sel_q;
         end
      end
   end

   // Read port; unknown codes read as zero. Bit 6 of the fault action word is always zero.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data_q  <= 16'h0000;
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= cmd_rd;
         if (cmd_rd) begin
            unique case (cmd_code)
               `CMD_FAULT_LIM: rd_data_q <= {8'h00, fault_lim_q};
               `CMD_WARN_LIM:  rd_data_q <= {8'h00, warn_lim_q};
               `CMD_FAULT_ACT: rd_data_q <= {8'h00, resp_sel_q, 1'b0,
                                             {3{retry_sel_q}}, {3{retry_sel_q}}};
               default:        rd_data_q <= 16'h0000;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Threshold detection
   // ----------------------------------------------------------------
   hyst_flag u_fault_flag (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .temp     (temp_sense),
      .limit    (fault_lim_q),
      .flag_q   (fault_flag)
   );

   hyst_flag u_warn_flag (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .temp     (temp_sense),
      .limit    (warn_lim_q),
      .flag_q   (warn_flag)
   );

   // The bandgap detector is asynchronous to the core clock.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         bg_meta_q <= 1'b0;
         bg_q      <= 1'b0;
      end else begin
         bg_meta_q <= bandgap_ot_pin;
         bg_q      <= bg_meta_q;
      end
   end

   // ----------------------------------------------------------------
   // Sticky status bits
   // ----------------------------------------------------------------
   // Set wins over clear, so a persisting condition reasserts at once.
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cml_q     <= 1'b0;
         ivd_q     <= 1'b0;
         sb_ot_q   <= 1'b0;
         sb_temp_q <= 1'b0;
         tf_q      <= 1'b0;
         tw_q      <= 1'b0;
      end else begin
         cml_q     <= reject || (cml_q && !clear_faults);
         ivd_q     <= reject || (ivd_q && !clear_faults);
         sb_ot_q   <= fault_flag || (sb_ot_q && !clear_faults);
         tf_q      <= fault_flag || (tf_q && !clear_faults);
         sb_temp_q <= warn_flag || fault_flag || (sb_temp_q && !clear_faults);
         tw_q      <= warn_flag || (tw_q && !clear_faults);
      end
   end

   assign comm_logic_fault          = cml_q;
   assign invalid_data_flag         = ivd_q;
   assign status_byte_overtemp_flag = sb_ot_q;
   assign status_byte_temp          = sb_temp_q;
   assign temp_fault_flag           = tf_q;
   assign temp_warning_level        = tw_q;
   assign smbalert = cml_q || ivd_q || sb_ot_q || tf_q || sb_temp_q || tw_q;

   // ----------------------------------------------------------------
   // Shutdown and retry sequencer
   // ----------------------------------------------------------------
   // Ignore mode keeps running; the bandgap detector can never be ignored.
   assign shut_req    = (fault_flag && resp_sel_q) || bg_q;
   assign cooled      = !fault_flag && !bg_q;
   assign timer_start = (state_q == SEQ_COOL) && cooled;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q      <= SEQ_RUN;
         soft_start_q <= 1'b0;
      end else begin
         soft_start_q <= 1'b0;
         unique case (state_q)
            SEQ_RUN: begin
               if (shut_req) begin
                  state_q <= retry_sel_q ? SEQ_COOL : SEQ_HOLD;
               end
            end
            SEQ_HOLD: begin
               if (clear_faults && cooled) begin
                  state_q      <= SEQ_RUN;
                  soft_start_q <= 1'b1;
               end
            end
            SEQ_COOL: begin
               if (cooled) begin
                  state_q <= SEQ_DELAY;
               end
            end
            SEQ_DELAY: begin
               if (shut_req) begin
                  state_q <= SEQ_COOL;
               end else if (timer_done) begin
                  state_q      <= SEQ_RUN;
                  soft_start_q <= 1'b1;
               end
            end
         endcase
      end
   end

   retry_timer #(
      .MS_CYC (MS_CYC)
   ) u_retry_timer (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .start    (timer_start),
      .ramp_ms  (soft_start_ramp_time),
      .done     (timer_done)
   );

   assign output_enable = power_on_cmd && (state_q == SEQ_RUN);

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   a_fault_trip: assert property (temp_sense > fault_lim_q |=> fault_flag)
      else $error("fault flag missed a trip");
   a_fault_hold: assert property (fault_flag && $stable(fault_lim_q) && temp_sense > fault_lim_q - `HYST_DEG
      |=> fault_flag)
      else $error("fault flag released early");
   a_warn_hold: assert property (warn_flag && $stable(warn_lim_q) && temp_sense > warn_lim_q - `HYST_DEG
      |=> warn_flag)
      else $error("warning flag released early");
   a_fault_status: assert property (fault_flag |=> status_byte_overtemp_flag && temp_fault_flag && smbalert)
      else $error("fault status not raised");
   a_warn_reject: assert property (wr_warn && !nvm_restore && !limit_check_override && wr_mant >= fault_lim_q
      |=> $stable(warn_lim_q) && comm_logic_fault && invalid_data_flag)
      else $error("bad warning write accepted");
   a_fault_reject: assert property (wr_fault && !nvm_restore && wr_mant <= warn_lim_q
      |=> $stable(fault_lim_q) && comm_logic_fault && invalid_data_flag)
      else $error("bad fault write accepted");
   a_retry_reject: assert property (wr_act && cmd_wdata[5:3] == 3'b010 |=> invalid_data_flag && smbalert)
      else $error("bad retry value accepted");
   a_action_read: assert property (cmd_rd && cmd_code == `CMD_FAULT_ACT
      |=> !rd_data_q[6] && rd_data_q[2:0] == {3{rd_data_q[5]}} && rd_data_q[5:3] == {3{rd_data_q[5]}})
      else $error("fault action readback malformed");
   a_bandgap_shut: assert property (bg_q |=> !output_enable)
      else $error("bandgap fault did not shut down");
   a_ignore_runs: assert property (state_q == SEQ_RUN && !resp_sel_q && !bg_q |=> state_q == SEQ_RUN)
      else $error("ignore mode shut down");

   c_fault_shutdown: cover property (state_q == SEQ_RUN ##1 state_q == SEQ_COOL);
   c_hold_release: cover property (state_q == SEQ_HOLD ##1 state_q == SEQ_RUN);
   c_retry_restart: cover property (state_q == SEQ_DELAY && timer_done);
   c_warn_reject: cover property (wr_warn && !warn_ok);
endmodule

// ---- host_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host side of the command port.
// ----------------------------------------------------------------
module host_model (
   input  wire logic    core_clk,
   output logic         cmd_wr,
   output logic         cmd_rd,
   output logic [7:0]   cmd_code,
   output logic [15:0]  cmd_wdata
);
   // Strobes idle low; code and data never keep a stale copy of the last request.
   initial begin
      cmd_wr = 1'b0;
      cmd_rd = 1'b0;
      cmd_code = 8'hA5;
      cmd_wdata = 16'h5A5A;
   end
   // One command per call, raised after a falling edge and held across exactly one rising edge.
   task automatic issue(input logic wr, input logic [7:0] code, input logic [15:0] data);
      @(negedge core_clk);
      cmd_wr = wr;
      cmd_rd = ~wr;
      cmd_code = code;
      cmd_wdata = data;
      @(negedge core_clk);
      cmd_wr = 1'b0;
      cmd_rd = 1'b0;
      cmd_code = ~code;
      cmd_wdata = ~data;
   endtask
endmodule

// ---- overtemp_limit_response_regs_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; $display("unexpected %0t got %0h want %0h", $time, a, b); end end
module overtemp_limit_response_regs_tb_top;
   import ot_limit_pkg::*;
   // ----------------------------------------------------------------
   // Stimulus and observed signals.
   // ----------------------------------------------------------------
   logic         core_clk, rst_b, cmd_wr, cmd_rd, clear_faults, limit_check_override, bandgap_ot_pin;
   logic         power_on_cmd, save_all_to_nvm, nvm_restore, nvm_resp_sel, nvm_retry_sel, rd_valid_q;
   logic         nvm_save_q, nvm_resp_sel_q, nvm_retry_sel_q, comm_logic_fault, invalid_data_flag;
   logic         status_byte_overtemp_flag, status_byte_temp, temp_fault_flag, temp_warning_level;
   logic         smbalert, output_enable, soft_start_q;
   logic [7:0]   cmd_code, cur_act, d;
   logic [15:0]  cmd_wdata, rd_data_q, exp_now;
   logic [6:0]   soft_start_ramp_time;
   temp_t        temp_sense, nvm_fault_lim, nvm_fault_lim_q;
   logic [15:0]  exp_q[$];
   int           errors, n_checks, seed, k;
   wire logic [6:0] fl = {comm_logic_fault, invalid_data_flag, status_byte_overtemp_flag, status_byte_temp,
                          temp_fault_flag, temp_warning_level, smbalert};

   // A short millisecond keeps the seven-period retry wait at 28 cycles.
   ot_limit_regs #(.MS_CYC(4)) ot_limit_regs_i (.core_clk, .rst_b, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata,
      .rd_data_q, .rd_valid_q, .clear_faults, .limit_check_override, .temp_sense, .bandgap_ot_pin,
      .power_on_cmd, .soft_start_ramp_time, .save_all_to_nvm, .nvm_restore, .nvm_fault_lim, .nvm_resp_sel,
      .nvm_retry_sel, .nvm_save_q, .nvm_fault_lim_q, .nvm_resp_sel_q, .nvm_retry_sel_q, .comm_logic_fault,
      .invalid_data_flag, .status_byte_overtemp_flag, .status_byte_temp, .temp_fault_flag,
      .temp_warning_level, .smbalert, .output_enable, .soft_start_q);
   host_model host_model_i (.core_clk, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata);

   // ----------------------------------------------------------------
   // Helpers.
   // ----------------------------------------------------------------
   task automatic cy(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] v);
      host_model_i.issue(1'b1, c, v);
   endtask
   // The expected word is queued before the read goes out.
   task automatic rd(input logic [7:0] c, input logic [15:0] e);
      exp_q.push_back(e);
      host_model_i.issue(1'b0, c, 16'h0000);
   endtask
   task automatic pulse(ref logic s);
      cy(1);
      s = 1'b1;
      cy(1);
      s = 1'b0;
   endtask
   // Clear only takes hold once the latched flag has dropped, so settle first.
   task automatic cool(input temp_t t);
      temp_sense = t;
      cy(2);
      pulse(clear_faults);
      cy(1);
   endtask
   task automatic wait_start();
      k = 0;
      while (soft_start_q !== 1'b1 && k < 50) begin
         cy(1);
         k++;
      end
      `CHK(soft_start_q, 1'b1)
      cy(1);
      `CHK(output_enable, 1'b1)
   endtask
   task automatic close_out();
      if (errors == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // Read results are matched against the oldest queued expectation.
   always @(negedge core_clk) begin
      if (rd_valid_q === 1'b1) begin
         exp_now = exp_q.pop_front();
         `CHK(rd_data_q, exp_now)
      end
   end
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // Generous bound; the sequence needs well under a thousand cycles.
   initial begin
      repeat (5000) @(posedge core_clk);
      errors++;
      close_out();
   end

   // ----------------------------------------------------------------
   // Main sequence.
   // ----------------------------------------------------------------
   initial begin
      seed = 32'h2AFE;
      errors = 0;
      n_checks = 0;
      {rst_b, clear_faults, limit_check_override, bandgap_ot_pin, save_all_to_nvm, nvm_restore} = 6'h00;
      {power_on_cmd, nvm_resp_sel, nvm_retry_sel} = 3'h5;
      soft_start_ramp_time = 7'h01;
      nvm_fault_lim = 8'h91;
      temp_sense = 8'h19;
      cy(6);
      rst_b = 1'b1;
      rd(8'h4F, 16'h0091);
      rd(8'h51, 16'h0078);
      rd(8'h50, 16'h003F);
      rd(8'h00, 16'h0000);
      `CHK(fl, 7'h00)
      wr(8'h51, 16'hFF82);
      rd(8'h51, 16'h0082);
      // Inconsistent and out-of-range limit writes.
      wr(8'h51, 16'h0091);
      wr(8'h4F, 16'h0082);
      wr(8'h4F, 16'h00A6);
      wr(8'h51, 16'h0063);
      rd(8'h4F, 16'h0091);
      rd(8'h51, 16'h0082);
      `CHK(fl, 7'h61)
      cool(8'h19);
      `CHK(fl, 7'h00)
      // The override lets the warning limit equal the fault limit.
      wr(8'h51, 16'h0064);
      wr(8'h4F, 16'h0078);
      limit_check_override = 1'b1;
      wr(8'h51, 16'h0078);
      rd(8'h51, 16'h0078);
      rd(8'h4F, 16'h0078);
      limit_check_override = 1'b0;
      `CHK(fl, 7'h00)
      // A low stored fault limit drives the derived warning limit onto its floor.
      nvm_fault_lim = 8'h78;
      pulse(nvm_restore);
      rd(8'h51, 16'h0064);
      nvm_fault_lim = 8'h91;
      pulse(nvm_restore);
      rd(8'h51, 16'h0078);
      rd(8'h50, 16'h003F);
      // Every retry code with random filler; only all-zero or all-one codes stick.
      cur_act = 8'h3F;
      for (int i = 0; i < 8; i++) begin
         d = 8'($random(seed));
         d[5:3] = 3'(i);
         temp_sense = 8'({$random(seed)} % 100);
         wr(8'h50, {8'h00, d});
         if (i == 0 || i == 7) cur_act = {d[7], 1'b0, {6{d[5]}}};
         rd(8'h50, {8'h00, cur_act});
         `CHK(comm_logic_fault, 1'(i != 0 && i != 7))
         pulse(clear_faults);
      end
      // Warning then fault under the ignore response.
      wr(8'h50, 16'h0038);
      temp_sense = 8'h79;
      cy(3);
      `CHK(fl, 7'h0B)
      cool(8'h65);
      `CHK(fl, 7'h0B)
      cool(8'h64);
      `CHK(fl, 7'h00)
      temp_sense = 8'h92;
      cy(3);
      `CHK(fl, 7'h1F)
      `CHK(output_enable, 1'b1)
      cool(8'h7E);
      `CHK(temp_fault_flag, 1'b1)
      cool(8'h7D);
      `CHK(temp_fault_flag, 1'b0)
      cool(8'h19);
      `CHK(fl, 7'h00)
      // Shutdown with endless retry after seven ramp periods.
      wr(8'h50, 16'h00B8);
      temp_sense = 8'h92;
      cy(4);
      `CHK(output_enable, 1'b0)
      temp_sense = 8'h19;
      cy(25);
      `CHK(output_enable, 1'b0)
      wait_start();
      // Shutdown with no retry holds until cleared.
      cool(8'h19);
      wr(8'h50, 16'h0080);
      temp_sense = 8'h92;
      cy(4);
      `CHK(output_enable, 1'b0)
      temp_sense = 8'h19;
      cy(50);
      `CHK(output_enable, 1'b0)
      cool(8'h19);
      cy(1);
      `CHK(output_enable, 1'b1)
      // Bandgap trip is never ignored; a zero ramp still waits seven 1 ms periods.
      soft_start_ramp_time = 7'h00;
      wr(8'h50, 16'h0038);
      bandgap_ot_pin = 1'b1;
      cy(5);
      `CHK(output_enable, 1'b0)
      bandgap_ot_pin = 1'b0;
      wait_start();
      wr(8'h4F, 16'h00A5);
      pulse(save_all_to_nvm);
      `CHK({nvm_save_q, nvm_fault_lim_q, nvm_resp_sel_q, nvm_retry_sel_q}, 11'h695)
      // Commanding the module off drops the power stage at once.
      power_on_cmd = 1'b0;
      cy(1);
      `CHK(output_enable, 1'b0)
      cy(2);
      `CHK(exp_q.size(), 0)
      close_out();
   end
endmodule
